// ==== src/irq_ctrl_cfg.svh ====
// Register offsets, field positions and reset values of the interrupt controller
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

`define OFF_AUX_REQ 8'h98
`define OFF_PRI_EN 8'ha8
`define OFF_PRI_PRIO 8'hb8
`define OFF_AUX_EN 8'he8
`define OFF_AUX_PRIO 8'hf8
`define OFF_EVT_STATUS 8'hc0
`define OFF_EVT_MASK 8'hc4

`define BIT_GLOBAL_GATE 7
`define BIT_SERIAL 5
`define BIT_TIMER1 3
`define BIT_EXT1 2
`define BIT_TIMER0 1
`define BIT_EXT0 0
`define BIT_CAPTION 6
`define BIT_BUSY 5

`define PRI_EN_MASK 8'haf
`define PRI_PRIO_MASK 8'h2f
`define AUX_MASK 8'h60
`define AUX_PRIO_FIXED 8'h60
`define REG_RESET 8'h00

`define VEC_EXT0 16'h0003
`define VEC_SERIAL 16'h002b
`define VEC_TIMER0 16'h000b
`define VEC_EXT1 16'h0013
`define VEC_BUSY 16'h0063
`define VEC_TIMER1 16'h001b
`define VEC_CAPTION 16'h006b

`endif

// ==== src/irq_ctrl_pkg.sv ====
// Types shared by the interrupt controller
`default_nettype none
package irq_ctrl_pkg;

    // Sources in polling order, highest first
    typedef enum logic [2:0] {
        SRC_EXT0,
        SRC_SERIAL,
        SRC_TIMER0,
        SRC_EXT1,
        SRC_BUSY,
        SRC_TIMER1,
        SRC_CAPTION,
        SRC_NONE
    } irq_src_t;

    typedef enum logic [1:0] {
        LVL_IDLE,
        LVL_LOW,
        LVL_HIGH
    } service_level_t;

    typedef struct packed {
        logic valid;
        irq_src_t source;
        logic high_level;
        logic [15:0] vector;
    } cpu_request_t;

endpackage : irq_ctrl_pkg
`default_nettype wire

// ==== src/two_level_interrupt_controller.sv ====
// Two-level interrupt controller with APB register access
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_cfg.svh"

module two_level_interrupt_controller
    import irq_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_input_0_req,
    input wire logic ext_input_1_req,
    input wire logic timer0_req,
    input wire logic timer1_req,
    input wire logic serial_unit_req,
    input wire logic caption_line_end,
    input wire logic display_busy_n,
    input wire logic cpu_ack,
    input wire logic cpu_reti,
    output cpu_request_t cpu_req,
    output logic irq
);

    logic [7:0] primary_source_enables;
    logic [7:0] primary_source_priorities;
    logic [7:0] auxiliary_source_enables;
    logic [7:0] auxiliary_request_flags;
    logic [7:0] evt_status;
    logic [7:0] evt_mask;
    logic busy_prev;
    logic low_active;
    logic high_active;
    cpu_request_t next_req;

    default clocking core_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Bus decode
    wire logic access = psel & penable;
    wire logic wr = access & pwrite;
    wire logic rd = access & ~pwrite;
    wire logic [7:0] addr = paddr[7:0];
    wire logic hit_req = paddr[31:8] == 24'h0 && addr == `OFF_AUX_REQ;
    wire logic hit_pen = paddr[31:8] == 24'h0 && addr == `OFF_PRI_EN;
    wire logic hit_ppr = paddr[31:8] == 24'h0 && addr == `OFF_PRI_PRIO;
    wire logic hit_aen = paddr[31:8] == 24'h0 && addr == `OFF_AUX_EN;
    wire logic hit_apr = paddr[31:8] == 24'h0 && addr == `OFF_AUX_PRIO;
    wire logic hit_sts = paddr[31:8] == 24'h0 && addr == `OFF_EVT_STATUS;
    wire logic hit_msk = paddr[31:8] == 24'h0 && addr == `OFF_EVT_MASK;
    wire logic hit_any = hit_req | hit_pen | hit_ppr | hit_aen | hit_apr
        | hit_sts | hit_msk;

    // Flag set events
    wire logic busy_fall = busy_prev & ~display_busy_n;
    wire logic caption_set = caption_line_end;

    // Pending sources, bit index = polling position
    wire logic [6:0] pending = {
        auxiliary_request_flags[`BIT_CAPTION],
        timer1_req,
        auxiliary_request_flags[`BIT_BUSY],
        ext_input_1_req,
        timer0_req,
        serial_unit_req,
        ext_input_0_req
    };

    wire logic [6:0] enables = {
        auxiliary_source_enables[`BIT_CAPTION],
        primary_source_enables[`BIT_TIMER1],
        auxiliary_source_enables[`BIT_BUSY],
        primary_source_enables[`BIT_EXT1],
        primary_source_enables[`BIT_TIMER0],
        primary_source_enables[`BIT_SERIAL],
        primary_source_enables[`BIT_EXT0]
    };

    wire logic [6:0] prio = {
        1'b1,
        primary_source_priorities[`BIT_TIMER1],
        1'b1,
        primary_source_priorities[`BIT_EXT1],
        primary_source_priorities[`BIT_TIMER0],
        primary_source_priorities[`BIT_SERIAL],
        primary_source_priorities[`BIT_EXT0]
    };

    // Live sample every cycle; of a denied request only the busy and caption flags are kept
    wire logic gate = primary_source_enables[`BIT_GLOBAL_GATE];
    wire logic [6:0] live = pending & enables & {7{gate}};
    wire logic [6:0] live_high = live & prio;
    wire logic [6:0] live_low = live & ~prio;
    wire logic use_high = |live_high;
    wire logic [6:0] cand = use_high ? live_high : live_low;
    wire logic allowed = use_high ? ~high_active
        : (~high_active & ~low_active);

    // Fixed polling order: lowest index wins
    function automatic irq_src_t first_src(input logic [6:0] v);
        irq_src_t s;
        s = SRC_NONE;
        for (int i = 6; i >= 0; i--) begin
            if (v[i]) begin
                s = irq_src_t'(i[2:0]);
            end
        end
        return s;
    endfunction : first_src

    function automatic logic [15:0] vec_of(input irq_src_t s);
        logic [15:0] v;
        case (s)
            SRC_EXT0: v = `VEC_EXT0;
            SRC_SERIAL: v = `VEC_SERIAL;
            SRC_TIMER0: v = `VEC_TIMER0;
            SRC_EXT1: v = `VEC_EXT1;
            SRC_BUSY: v = `VEC_BUSY;
            SRC_TIMER1: v = `VEC_TIMER1;
            SRC_CAPTION: v = `VEC_CAPTION;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : vec_of

    wire irq_src_t sel = first_src(cand);
    always_comb begin
        next_req.valid = allowed & (|cand);
        next_req.source = next_req.valid ? sel : SRC_NONE;
        next_req.high_level = next_req.valid & use_high;
        next_req.vector = next_req.valid ? vec_of(sel) : 16'h0000;
    end

    wire logic [7:0] stat_evt = {1'b0, caption_set, busy_fall,
        next_req.valid & cpu_ack, 4'h0};
    // Clear only what the read reported, so a fresh event is not lost
    wire logic [7:0] sts_clear = (rd && hit_sts) ? prdata[7:0] : 8'h00;
    wire logic [7:0] req_wdata = pwdata[7:0] & `AUX_MASK;

    // APB registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_source_enables <= `REG_RESET;
            primary_source_priorities <= `REG_RESET;
            auxiliary_source_enables <= `REG_RESET;
            evt_mask <= `REG_RESET;
        end else if (wr) begin
            if (hit_pen) begin
                primary_source_enables <= pwdata[7:0] & `PRI_EN_MASK;
            end
            if (hit_ppr) begin
                primary_source_priorities <= pwdata[7:0] & `PRI_PRIO_MASK;
            end
            if (hit_aen) begin
                auxiliary_source_enables <= pwdata[7:0] & `AUX_MASK;
            end
            if (hit_msk) begin
                evt_mask <= pwdata[7:0] & `AUX_MASK;
            end
        end
    end

    // Request flags: hardware set beats software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auxiliary_request_flags <= `REG_RESET;
            busy_prev <= 1'b1;
        end else begin
            busy_prev <= display_busy_n;
            auxiliary_request_flags <= ((wr && hit_req) ? req_wdata
                : auxiliary_request_flags)
                | {1'b0, caption_set, busy_fall, 5'h0};
        end
    end

    // Sticky event status, cleared by read; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= `REG_RESET;
        end else begin
            evt_status <= (evt_status & ~sts_clear) | stat_evt;
        end
    end

    // In-service levels; acceptance enters, return leaves the top level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_active <= 1'b0;
            high_active <= 1'b0;
        end else if (next_req.valid && cpu_ack) begin
            if (next_req.high_level) begin
                high_active <= 1'b1;
            end else begin
                low_active <= 1'b1;
            end
        end else if (cpu_reti) begin
            if (high_active) begin
                high_active <= 1'b0;
            end else begin
                low_active <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_req <= '{valid: 1'b0, source: SRC_NONE, high_level: 1'b0,
                vector: 16'h0000};
        end else begin
            cpu_req <= next_req;
        end
    end

    wire logic [7:0] rd_mux =
        hit_req ? auxiliary_request_flags :
        hit_pen ? primary_source_enables :
        hit_ppr ? primary_source_priorities :
        hit_aen ? auxiliary_source_enables :
        hit_apr ? `AUX_PRIO_FIXED :
        hit_sts ? evt_status :
        hit_msk ? evt_mask : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h0, rd_mux};
        end
    end

    // Zero-wait slave; unmapped accesses raise an error
    assign pready = 1'b1;
    assign pslverr = access & ~hit_any;
    assign irq = |(evt_status & evt_mask);

    // Assertions
    a_gate_blocks_req: assert property (
        !gate |=> !cpu_req.valid)
        else $error("request passed while global gate low");

    a_high_no_preempt: assert property (
        high_active |=> !cpu_req.valid)
        else $error("request issued during high level service");

    a_low_preempted: assert property (
        low_active && !high_active && |live_high
        |=> cpu_req.valid && cpu_req.high_level)
        else $error("high request did not preempt low routine");

    a_high_wins: assert property (
        (|live_high) && (|live_low) && !high_active |=> cpu_req.high_level)
        else $error("low level chosen over high level");

    a_poll_ext0_top: assert property (
        live[0] && prio[0] == use_high && allowed
        |=> cpu_req.source == SRC_EXT0)
        else $error("external input 0 lost polling order");

    sequence busy_edge_s;
        $fell(display_busy_n);
    endsequence

    a_busy_sets_flag: assert property (
        busy_edge_s |=> auxiliary_request_flags[`BIT_BUSY])
        else $error("busy edge did not set flag");

    // A set flag keeps asking until software clears it
    a_busy_pending: assert property (
        auxiliary_request_flags[`BIT_BUSY]
        && auxiliary_source_enables[`BIT_BUSY] && gate && !high_active
        |=> cpu_req.valid)
        else $error("pending busy request not presented");

    a_caption_sets: assert property (
        caption_line_end |=> auxiliary_request_flags[`BIT_CAPTION])
        else $error("caption flag not set");

    a_flag_sticky: assert property (
        auxiliary_request_flags[`BIT_BUSY] && !(wr && hit_req)
        |=> auxiliary_request_flags[`BIT_BUSY])
        else $error("busy flag cleared by hardware");

    a_flag_write: assert property (
        wr && hit_req |=> auxiliary_request_flags[`BIT_BUSY]
        == ($past(pwdata[`BIT_BUSY]) | $past(busy_fall)))
        else $error("busy flag write landed in wrong bit");

    a_busy_vector: assert property (
        cpu_req.valid && cpu_req.source == SRC_BUSY
        |-> cpu_req.vector == `VEC_BUSY)
        else $error("busy vector wrong");

    a_enable_gates: assert property (
        next_req.valid |-> enables[next_req.source])
        else $error("disabled source selected");

    a_denied_forgotten: assert property (
        !(|live) |=> !cpu_req.valid)
        else $error("request issued with no live source");

    a_low_waits: assert property (
        low_active && !(|live_high) |=> !cpu_req.valid)
        else $error("low request issued during low level service");

    sequence accept_high_s;
        next_req.valid && next_req.high_level && cpu_ack;
    endsequence

    sequence accept_low_s;
        next_req.valid && !next_req.high_level && cpu_ack;
    endsequence

    a_enter_high: assert property (
        accept_high_s |=> high_active)
        else $error("accepted high request not in service");

    a_enter_low: assert property (
        accept_low_s |=> low_active)
        else $error("accepted low request not in service");

    a_return_high: assert property (
        cpu_reti && high_active && !(next_req.valid && cpu_ack)
        |=> !high_active)
        else $error("return left high level service active");

endmodule : two_level_interrupt_controller
`default_nettype wire

// ==== tb/cpu_model.sv ====
// CPU core stand-in: acknowledges requests and returns from service
`timescale 1ns/1ps
`default_nettype none
module cpu_model
    import irq_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire cpu_request_t cpu_req,
    input wire logic ack_en,
    input wire logic reti_cmd,
    output logic cpu_ack,
    output logic cpu_reti
);
    logic seen;
    // Remember only an acked request, so a late enable still acks
    wire logic take = ack_en && cpu_req.valid && !seen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            cpu_reti <= 1'b0;
            seen <= 1'b0;
        end else begin
            cpu_ack <= take;
            seen <= cpu_req.valid && (seen || take);
            cpu_reti <= reti_cmd;
        end
    end
endmodule : cpu_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import irq_ctrl_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, cpu_ack, cpu_reti, irq, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [4:0] lv = 5'h0;
    logic line_end = 1'b0, busy_n = 1'b1, ack_en = 1'b0, reti_cmd = 1'b0;
    cpu_request_t cpu_req;
    int n_errors = 0, tests_run = 0, cycles = 0;
    irq_src_t ord [5] = '{SRC_EXT0, SRC_SERIAL, SRC_TIMER0, SRC_EXT1,
                          SRC_TIMER1};
    logic [7:0] ra [4] = '{8'ha8, 8'hb8, 8'he8, 8'h98};
    logic [7:0] rv [4] = '{8'haf, 8'h2f, 8'h60, 8'h60};

    two_level_interrupt_controller two_level_interrupt_controller_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_input_0_req(lv[0]),
        .serial_unit_req(lv[1]), .timer0_req(lv[2]), .ext_input_1_req(lv[3]),
        .timer1_req(lv[4]), .caption_line_end(line_end),
        .display_busy_n(busy_n), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti),
        .cpu_req(cpu_req), .irq(irq));
    cpu_model cpu_model_inst (.pclk(pclk), .presetn(presetn),
        .cpu_req(cpu_req), .ack_en(ack_en), .reti_cmd(reti_cmd),
        .cpu_ack(cpu_ack), .cpu_reti(cpu_reti));

    initial begin
        forever #2 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("compared %0d, mismatched %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // Ack path needs up to four edges to settle, so wait six
    task automatic req_chk(input logic v, input irq_src_t s);
        repeat (6) @(posedge pclk);
        chk({31'h0, cpu_req.valid}, {31'h0, v}, "request valid");
        if (v) chk({29'h0, cpu_req.source}, {29'h0, s}, "request source");
    endtask : req_chk

    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic reti();
        @(posedge pclk);
        reti_cmd <= 1'b1;
        @(posedge pclk);
        reti_cmd <= 1'b0;
    endtask : reti

    // Only defined bits are ever written as ones
    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, {24'h0, ra[i]}, 32'h0);
            chk(rd, 32'h0, "reset value");
            apb(1'b1, {24'h0, ra[i]}, {24'h0, rv[i]});
            apb(1'b0, {24'h0, ra[i]}, 32'h0);
            chk(rd, {24'h0, rv[i]}, "register bits");
            apb(1'b1, {24'h0, ra[i]}, 32'h0);
        end
        apb(1'b1, 32'hf8, 32'h0);
        apb(1'b0, 32'hf8, 32'h0);
        chk(rd, 32'h60, "fixed priorities");
        apb(1'b0, 32'h4, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("registers test done");
    endtask : t_regs

    task automatic t_gate();
        apb(1'b1, 32'ha8, 32'h02);
        lv <= 5'h04;
        req_chk(1'b0, SRC_NONE);
        apb(1'b1, 32'ha8, 32'h80);
        req_chk(1'b0, SRC_NONE);
        apb(1'b1, 32'ha8, 32'h82);
        req_chk(1'b1, SRC_TIMER0);
        lv <= 5'h0;
        $display("gate test done");
    endtask : t_gate

    task automatic t_order();
        apb(1'b1, 32'ha8, 32'haf);
        for (int i = 0; i < 5; i++) begin
            lv <= 5'h1f << i;
            req_chk(1'b1, ord[i]);
        end
        apb(1'b1, 32'hb8, 32'h08);
        lv <= 5'h11;
        req_chk(1'b1, SRC_TIMER1);
        lv <= 5'h0;
        apb(1'b1, 32'hb8, 32'h0);
        $display("order test done");
    endtask : t_order

    task automatic t_flags();
        apb(1'b0, 32'hc0, 32'h0);
        apb(1'b1, 32'ha8, 32'h80);
        apb(1'b1, 32'he8, 32'h20);
        busy_n <= 1'b0;
        req_chk(1'b1, SRC_BUSY);
        chk({16'h0, cpu_req.vector}, 32'h63, "busy vector");
        chk({31'h0, cpu_req.high_level}, 32'h1, "busy level");
        chk({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b1, 32'hc4, 32'h60);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1, "unmasked irq");
        busy_n <= 1'b1;
        @(posedge pclk);
        busy_n <= 1'b0;
        apb(1'b0, 32'h98, 32'h0);
        chk(rd, 32'h20, "busy flag");
        apb(1'b0, 32'hc0, 32'h0);
        chk(rd, 32'h20, "event status");
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq after read");
        apb(1'b1, 32'h98, 32'h0);
        req_chk(1'b0, SRC_NONE);
        apb(1'b1, 32'he8, 32'h40);
        line_end <= 1'b1;
        @(posedge pclk);
        line_end <= 1'b0;
        apb(1'b0, 32'h98, 32'h0);
        chk(rd, 32'h40, "caption flag");
        req_chk(1'b1, SRC_CAPTION);
        apb(1'b1, 32'h98, 32'h0);
        apb(1'b1, 32'he8, 32'h0);
        busy_n <= 1'b1;
        $display("flags test done");
    endtask : t_flags

    task automatic t_nest();
        apb(1'b1, 32'ha8, 32'h8f);
        apb(1'b1, 32'hb8, 32'h0c);
        lv <= 5'h04;
        ack_en <= 1'b1;
        req_chk(1'b0, SRC_NONE);
        ack_en <= 1'b0;
        lv <= 5'h0c;
        req_chk(1'b1, SRC_EXT1);
        ack_en <= 1'b1;
        repeat (6) @(posedge pclk);
        lv <= 5'h1d;
        req_chk(1'b0, SRC_NONE);
        ack_en <= 1'b0;
        lv <= 5'h04;
        reti();
        req_chk(1'b0, SRC_NONE);
        reti();
        req_chk(1'b1, SRC_TIMER0);
        lv <= 5'h0;
        apb(1'b0, 32'hc0, 32'h0);
        chk(rd, 32'h50, "accept and caption events");
        $display("nesting test done");
    endtask : t_nest

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_gate();
        t_order();
        t_flags();
        t_nest();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
